// ==== rtl/bcht_params.svh ====
// Offsets, field positions and reset values of the configuration header tail
`ifndef BCHT_PARAMS_SVH
`define BCHT_PARAMS_SVH

`define BCHT_OFS_UPPER_BASE   12'h024
`define BCHT_OFS_RSVD_A       12'h028
`define BCHT_OFS_SUBSYS_ID    12'h02C
`define BCHT_OFS_RSVD_B       12'h030
`define BCHT_OFS_CAP_PTR      12'h034
`define BCHT_OFS_OPTION_ROM   12'h038
`define BCHT_OFS_IRQ_MISC     12'h03C
`define BCHT_OFS_UPPER_SETUP  12'h018

`define BCHT_UPPER_BASE_RST   32'h00000000
`define BCHT_CAP_PTR_VAL      8'h80
`define BCHT_IRQ_LINE_RST     8'h00
`define BCHT_IRQ_PIN_REVERSE  8'h01
`define BCHT_IRQ_PIN_FORWARD  8'h00
`define BCHT_MIN_GNT_RST      8'h00
`define BCHT_MAX_LAT_RST      8'h00
`define BCHT_SETUP_EN_BIT     31
`define BCHT_SUBSYS_VID_DFLT  16'hA5C3
`define BCHT_SUBSYS_DID_DFLT  16'h3C5A

`endif

// ==== rtl/bcht_pkg.sv ====
// Types shared by the configuration header tail
package bcht_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } bcht_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } bcht_apb_rsp_t;

   typedef enum logic [1:0] {
      BCHT_IDLE   = 2'b01,
      BCHT_ACCESS = 2'b10
   } bcht_state_t;
endpackage

// ==== rtl/bcht_top.sv ====
// Configuration header tail register bank, offsets 24h to 3Ch, over APB
`timescale 1ns/100ps
`include "bcht_params.svh"

module bcht_top #(
   parameter logic [15:0] SUBSYS_VID = `BCHT_SUBSYS_VID_DFLT,  // Arbitrary value
   parameter logic [15:0] SUBSYS_DID = `BCHT_SUBSYS_DID_DFLT   // Arbitrary value
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   clk_en,
   input  wire bcht_pkg::bcht_apb_req_t apb_req,
   output      bcht_pkg::bcht_apb_rsp_t apb_rsp,
   input  wire logic [31:0]            upper_setup,
   input  wire logic                   reverse_mode,
   output      logic [31:0]            upper_base,
   output      logic                   upper_base_en
);
   import bcht_pkg::*;

   // ***************************************
   // Storage
   // ***************************************
   logic [31:0] upper_base_ff;
   logic [7:0]  irq_line_ff;
   logic [7:0]  irq_pin_ff;
   logic        rst_seen_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        upper_en_ff;
   logic [31:0] out_base_ff;
   bcht_state_t state_ff;
   bcht_state_t nxt_state;
   logic [31:0] nxt_rdata;
   logic [31:0] nxt_upper_base;
   logic [31:0] wmask;
   logic [31:0] bytemask;
   logic        setup_pulse;
   logic        wr_hit;
   logic        pslverr_ff;

   // ***************************************
   // Bus handshake
   // ***************************************
   assign setup_pulse = apb_req.psel && !apb_req.penable;
   assign wr_hit      = (state_ff == BCHT_ACCESS) && apb_req.psel && apb_req.penable && apb_req.pwrite;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         BCHT_IDLE: begin
            if (setup_pulse) begin
               nxt_state = BCHT_ACCESS;
            end
         end
         BCHT_ACCESS: begin
            nxt_state = BCHT_IDLE;
         end
         default: begin
            nxt_state = BCHT_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff  <= BCHT_IDLE;
         pready_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff  <= nxt_state;
         pready_ff <= (state_ff == BCHT_IDLE) && setup_pulse;
      end
   end

   // ***************************************
   // Upper base write path
   // ***************************************
   generate
      for (genvar b = 0; b < 4; b++) begin : g_lane
         assign bytemask[b*8 +: 8] = {8{apb_req.pstrb[b]}};
      end
   endgenerate

   assign wmask = upper_setup & bytemask;

   always_comb begin
      nxt_upper_base = upper_base_ff;
      if (wr_hit && pready_ff && apb_req.paddr == `BCHT_OFS_UPPER_BASE) begin
         nxt_upper_base = (apb_req.pwdata & wmask) | (upper_base_ff & ~wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_base_ff <= `BCHT_UPPER_BASE_RST;
      end else if (clk_en) begin
         upper_base_ff <= nxt_upper_base;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_en_ff <= 1'b0;
         out_base_ff <= `BCHT_UPPER_BASE_RST;
      end else if (clk_en) begin
         upper_en_ff <= upper_setup[`BCHT_SETUP_EN_BIT];
         out_base_ff <= upper_setup[`BCHT_SETUP_EN_BIT] ? nxt_upper_base : 32'h00000000;
      end
   end

   assign upper_base    = out_base_ff;
   assign upper_base_en = upper_en_ff;

   // ***************************************
   // Interrupt line and pin bytes
   // ***************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_line_ff <= `BCHT_IRQ_LINE_RST;
      end else if (clk_en) begin
         if (wr_hit && pready_ff && apb_req.paddr == `BCHT_OFS_IRQ_MISC && apb_req.pstrb[0]) begin
            irq_line_ff <= apb_req.pwdata[7:0];
         end
      end
   end

   // Pin byte follows the mode strap caught after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pin_ff  <= `BCHT_IRQ_PIN_FORWARD;
         rst_seen_ff <= 1'b0;
      end else if (clk_en) begin
         if (!rst_seen_ff) begin
            irq_pin_ff  <= reverse_mode ? `BCHT_IRQ_PIN_REVERSE : `BCHT_IRQ_PIN_FORWARD;
            rst_seen_ff <= 1'b1;
         end
      end
   end

   // ***************************************
   // Read path
   // ***************************************
   always_comb begin
      nxt_rdata = 32'h00000000;
      case (apb_req.paddr)
         `BCHT_OFS_UPPER_BASE: nxt_rdata = upper_base_ff;
         `BCHT_OFS_SUBSYS_ID:  nxt_rdata = {SUBSYS_DID, SUBSYS_VID};
         `BCHT_OFS_CAP_PTR:    nxt_rdata = {24'h000000, `BCHT_CAP_PTR_VAL};
         `BCHT_OFS_OPTION_ROM: nxt_rdata = 32'h00000000;
         `BCHT_OFS_IRQ_MISC:   nxt_rdata = {`BCHT_MAX_LAT_RST, `BCHT_MIN_GNT_RST, irq_pin_ff, irq_line_ff};
         default:              nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else if (clk_en) begin
         if ((state_ff == BCHT_IDLE) && setup_pulse && !apb_req.pwrite) begin
            prdata_ff <= nxt_rdata;
         end else begin
            prdata_ff <= 32'h00000000;
         end
      end
   end

   // Unmapped or locked accesses never raise an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else if (clk_en) begin
         pslverr_ff <= 1'b0;
      end
   end

   assign apb_rsp.prdata  = prdata_ff;
   assign apb_rsp.pready  = pready_ff;
   assign apb_rsp.pslverr = pslverr_ff;

   // ***************************************
   // Checks
   // ***************************************
   masked_write_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && wr_hit && pready_ff && apb_req.paddr == `BCHT_OFS_UPPER_BASE |=>
      ((upper_base_ff ^ $past(upper_base_ff)) & ~$past(wmask)) == 32'h00000000)
      else $error("upper base changed a locked bit");
   base_disable_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !upper_setup[`BCHT_SETUP_EN_BIT] |=> upper_base == 32'h00000000 && !upper_base_en)
      else $error("disabled upper base seen");
   base_reset_a : assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rst_seen_ff) |-> upper_base_ff == 32'h00000000 || $past(wr_hit))
      else $error("upper base not zero after reset");
   cap_read_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse && !apb_req.pwrite && apb_req.paddr == `BCHT_OFS_CAP_PTR
      |=> apb_rsp.prdata == 32'h00000080 && apb_rsp.pready)
      else $error("capability pointer wrong");
   rom_read_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse && apb_req.paddr == `BCHT_OFS_OPTION_ROM
      |=> apb_rsp.prdata == 32'h00000000)
      else $error("option ROM base not zero");
   rsvd_read_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && setup_pulse && (apb_req.paddr == `BCHT_OFS_RSVD_A || apb_req.paddr == `BCHT_OFS_RSVD_B)
      |=> apb_rsp.prdata == 32'h00000000)
      else $error("reserved slot not zero");
   subsys_read_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse && !apb_req.pwrite && apb_req.paddr == `BCHT_OFS_SUBSYS_ID
      |=> apb_rsp.prdata == {SUBSYS_DID, SUBSYS_VID})
      else $error("subsystem identification wrong");
   pin_mode_a : assert property (@(posedge pclk) disable iff (!presetn)
      rst_seen_ff |-> irq_pin_ff == `BCHT_IRQ_PIN_REVERSE || irq_pin_ff == `BCHT_IRQ_PIN_FORWARD)
      else $error("interrupt pin byte invalid");
   line_write_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && wr_hit && pready_ff && apb_req.paddr == `BCHT_OFS_IRQ_MISC && apb_req.pstrb[0]
      |=> irq_line_ff == $past(apb_req.pwdata[7:0]))
      else $error("interrupt line not stored");
   hint_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && setup_pulse && state_ff == BCHT_IDLE && apb_req.paddr == `BCHT_OFS_IRQ_MISC
      |=> apb_rsp.prdata[31:16] == 16'h0000)
      else $error("grant or latency hint not zero");

   // ***************************************
   // Bus protocol checks
   // ***************************************
   ready_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && pready_ff |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");

   ready_answer_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse |=> apb_rsp.pready)
      else $error("setup phase not answered");

   rdata_quiet_a : assert property (@(posedge pclk) disable iff (!presetn)
      !apb_rsp.pready |-> apb_rsp.prdata == 32'h00000000)
      else $error("read data outside access cycle");

   slverr_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
      apb_rsp.pready |-> !apb_rsp.pslverr)
      else $error("error response raised");

   write_no_data_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse && apb_req.pwrite
      |=> apb_rsp.prdata == 32'h00000000)
      else $error("write returned read data");

   state_onehot_a : assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(state_ff))
      else $error("handshake state not one-hot");

   freeze_a : assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(upper_base_ff) && $stable(irq_line_ff) && $stable(upper_base)
      && $stable(upper_base_en) && $stable(apb_rsp.pready))
      else $error("state moved while clock enable low");

   // ***************************************
   // Register checks
   // ***************************************
   en_follow_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en |=> upper_base_en == $past(upper_setup[`BCHT_SETUP_EN_BIT]))
      else $error("window enable does not follow setup");

   base_follow_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && upper_setup[`BCHT_SETUP_EN_BIT] |=> upper_base == upper_base_ff)
      else $error("enabled window base differs from stored base");

   other_write_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !(wr_hit && apb_req.paddr == `BCHT_OFS_UPPER_BASE) |=> $stable(upper_base_ff))
      else $error("upper base changed without its write");

   base_read_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse && !apb_req.pwrite && apb_req.paddr == `BCHT_OFS_UPPER_BASE
      |=> apb_rsp.prdata == $past(upper_base_ff))
      else $error("upper base readback wrong");

   line_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !(wr_hit && apb_req.paddr == `BCHT_OFS_IRQ_MISC && apb_req.pstrb[0])
      |=> $stable(irq_line_ff))
      else $error("interrupt line changed without its write");

   line_read_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_ff == BCHT_IDLE && setup_pulse && !apb_req.pwrite && apb_req.paddr == `BCHT_OFS_IRQ_MISC
      |=> apb_rsp.prdata[15:0] == {$past(irq_pin_ff), $past(irq_line_ff)})
      else $error("interrupt line or pin readback wrong");

   pin_latch_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !rst_seen_ff
      |=> irq_pin_ff == ($past(reverse_mode) ? `BCHT_IRQ_PIN_REVERSE : `BCHT_IRQ_PIN_FORWARD))
      else $error("interrupt pin byte not taken from mode");

   pin_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
      rst_seen_ff |=> $stable(irq_pin_ff))
      else $error("interrupt pin byte changed after reset");

   mode_seen_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en |=> rst_seen_ff)
      else $error("mode strap not taken");

   // ***************************************
   // Per bit lock checks
   // ***************************************
   generate
      for (genvar i = 0; i < 32; i++) begin : g_bit_lock
         bit_lock_a : assert property (@(posedge pclk) disable iff (!presetn)
            clk_en && !upper_setup[i] |=> $stable(upper_base_ff[i]))
            else $error("locked upper base bit changed");
      end
   endgenerate
endmodule

// ==== sim/bridge_config_header_tail_bench.sv ====
// Self-checking bench for the configuration header tail register bank
`timescale 1ns/100ps
`include "bcht_params.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module bridge_config_header_tail_bench;
   import bcht_pkg::*;
   localparam logic [15:0] VID = 16'h1D2E;  // Arbitrary value
   localparam logic [15:0] DID = 16'h6B07;  // Arbitrary value
   logic          pclk = 1'b0;
   logic          presetn;
   logic          clk_en;
   logic          rev;
   bcht_apb_req_t req;
   bcht_apb_rsp_t rsp;
   logic [31:0]   setup;
   logic [31:0]   base;
   logic          en;
   logic [31:0]   base_m;
   logic [31:0]   wd;
   logic [31:0]   msk;
   logic [3:0]    st;
   logic [31:0]   exp_q[$];
   logic [31:0]   e;
   int            error_cnt;
   int            n_compared;
   int            cycles;
   logic [11:0]   ro_a[5] = '{`BCHT_OFS_RSVD_A, `BCHT_OFS_SUBSYS_ID, `BCHT_OFS_RSVD_B,
                              `BCHT_OFS_CAP_PTR, `BCHT_OFS_OPTION_ROM};
   logic [31:0]   ro_e[5] = '{32'h0, {DID, VID}, 32'h0, 32'h80, 32'h0};

   always #4 pclk = ~pclk;

   bcht_top #(.SUBSYS_VID(VID), .SUBSYS_DID(DID)) dut (
      .pclk          (pclk),
      .presetn       (presetn),
      .clk_en        (clk_en),
      .apb_req       (req),
      .apb_rsp       (rsp),
      .upper_setup   (setup),
      .reverse_mode  (rev),
      .upper_base    (base),
      .upper_base_en (en)
   );

   task results;
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [31:0] ex);
      if (!w) exp_q.push_back(ex);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      req.pstrb <= s;
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] ex);
      xfer(1'b0, a, 32'h0, 4'hF, ex);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      xfer(1'b1, a, d, s, 32'h0);
   endtask

   task do_reset(input logic r);
      presetn <= 1'b0;
      rev <= r;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // ****************
   // Read data check
   // ****************
   always @(posedge pclk) begin
      if (presetn === 1'b1 && rsp.pready === 1'b1 && req.pwrite === 1'b0) begin
         if (exp_q.size() == 0) begin
            `CHK("unexpected read", 1'b0, 1'b1)
         end else begin
            e = exp_q.pop_front();
            `CHK("prdata", e, rsp.prdata)
         end
      end
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         results();
      end
   end

   // ****************
   // Main sequence
   // ****************
   initial begin
      req = '0;
      setup = 32'h0;
      rev = 1'b1;
      clk_en = 1'b1;
      presetn = 1'b0;
      base_m = 32'h0;
      error_cnt = 0;
      n_compared = 0;
      cycles = 0;
      void'($urandom(32'h283d));
      do_reset(1'b1);
      rd(`BCHT_OFS_UPPER_BASE, 32'h0);
      rd(`BCHT_OFS_IRQ_MISC, 32'h00000100);
      rd(12'h040, 32'h0);
      for (int i = 0; i < 5; i++) begin
         rd(ro_a[i], ro_e[i]);
         wr(ro_a[i], 32'hFFFFFFFF, 4'hF);
         rd(ro_a[i], ro_e[i]);
      end
      wd = $urandom;
      wr(`BCHT_OFS_IRQ_MISC, wd, 4'hF);
      rd(`BCHT_OFS_IRQ_MISC, {16'h0, 8'h01, wd[7:0]});
      for (int i = 0; i < 8; i++) begin
         setup <= {1'b1, 31'($urandom)};
         wd = $urandom;
         st = 4'($urandom);
         @(posedge pclk);
         msk = setup & {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
         base_m = (wd & msk) | (base_m & ~msk);
         wr(`BCHT_OFS_UPPER_BASE, wd, st);
         #1 `CHK("upper_base", base_m, base)
         `CHK("upper_base_en", 1'b1, en)
         @(posedge pclk);
         rd(`BCHT_OFS_UPPER_BASE, base_m);
      end
      clk_en <= 1'b0;
      setup <= 32'h0;
      repeat (3) @(posedge pclk);
      #1 `CHK("frozen upper_base", base_m, base)
      `CHK("frozen upper_base_en", 1'b1, en)
      @(posedge pclk);
      clk_en <= 1'b1;
      setup <= 32'h7FFFFFFF;
      repeat (2) @(posedge pclk);
      #1 `CHK("upper_base off", 32'h0, base)
      `CHK("upper_base_en off", 1'b0, en)
      @(posedge pclk);
      do_reset(1'b0);
      rd(`BCHT_OFS_IRQ_MISC, 32'h0);
      rd(`BCHT_OFS_UPPER_BASE, 32'h0);
      results();
   end
endmodule
